/* rtl/asrc_ctrl.sv */
/*
 * Host controller for an asynchronous 128K x 8 static memory. It takes
 * one byte request at a time and turns it into pin sequences on the
 * memory's select, output gate, write strobe, address and data pins.
 * Assumes the memory pins are wired straight to the outputs, the data
 * bus is resolved outside from dq_out and dq_oe_n, and dq_in is sampled
 * synchronously. The memory contents are undefined until written.
 */
`timescale 1ns/1ps

// Behaviour
// - strobe rise ends write, data held across
// - gate low writes need turnoff plus setup
// - address valid no later than select fall
// - host never drives while memory drives
module asrc_ctrl (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst,
	// Request port
	input  wire logic                        req_valid,
	input  wire logic                        req_write,
	input  wire logic [asrc_pkg::ADDR_W-1:0] req_addr,
	input  wire logic [asrc_pkg::DATA_W-1:0] req_wdata,
	output      logic                        req_ready,
	// Read answer
	output      logic                        rd_valid,
	output      logic [asrc_pkg::DATA_W-1:0] rd_data,
	// Memory pins
	output      asrc_pkg::asrc_pins_s        pins,
	input  wire logic [asrc_pkg::DATA_W-1:0] dq_in,
	output      logic [asrc_pkg::DATA_W-1:0] dq_out,
	output      logic                        dq_oe_n
);

	asrc_pkg::asrc_state_e           state;
	asrc_pkg::asrc_state_e           next_state;
	logic                            accept;
	logic                            tmr_load;
	logic [asrc_pkg::TMR_W-1:0]      tmr_val;
	logic                            tmr_done;
	logic                            rd_end;
	logic                            wr_end;

	// ==========================================================
	// Decode
	// A request is taken only when idle and advertised ready
	assign accept   = (state == asrc_pkg::ST_IDLE) && req_valid && req_ready;
	assign rd_end   = (state == asrc_pkg::ST_RD_ACC) && tmr_done;
	assign wr_end   = (state == asrc_pkg::ST_WR_PULSE) && tmr_done;
	assign tmr_load = accept;
	// Write length covers strobe turnoff plus data setup
	assign tmr_val  = req_write ? (asrc_pkg::WR_CYC - asrc_pkg::TMR_ONE)
		: (asrc_pkg::ACC_CYC - asrc_pkg::TMR_ONE);

	// Next state
	always_comb begin
		next_state = state;
		unique case (state)
			asrc_pkg::ST_IDLE: begin
				if (accept) begin
					next_state = req_write ? asrc_pkg::ST_WR_PULSE
						: asrc_pkg::ST_RD_ACC;
				end
			end
			asrc_pkg::ST_RD_ACC: begin
				if (rd_end) begin
					next_state = asrc_pkg::ST_IDLE;
				end
			end
			asrc_pkg::ST_WR_PULSE: begin
				if (wr_end) begin
					next_state = asrc_pkg::ST_WR_HOLD;
				end
			end
			asrc_pkg::ST_WR_HOLD: begin
				next_state = asrc_pkg::ST_IDLE;
			end
			default: begin
				next_state = asrc_pkg::ST_IDLE;
			end
		endcase
	end

	// ==========================================================
	// Phase timer
	asrc_timer u_timer (
		.clk      (clk),
		.rst      (rst),
		.load     (tmr_load),
		.load_val (tmr_val),
		.expired  (tmr_done)
	);

	// ==========================================================
	// Sequencer state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= asrc_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Memory pins live in one process so the bundle has a single driver.
	// Address and select move together on accept
	// Output gate opens only for reads, so writes never fight
	// Strobe and select rise on one edge to end the write
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pins <= asrc_pkg::PINS_IDLE; // Standby until a request
		end else if (accept) begin
			pins.addr           <= req_addr;
			pins.chip_sel_n     <= 1'b0;
			pins.out_gate_n     <= req_write;
			pins.write_strobe_n <= !req_write;
		end else if (rd_end || wr_end) begin
			// Gate was already high in a write, strobe in a read
			pins.chip_sel_n     <= 1'b1;
			pins.out_gate_n     <= 1'b1;
			pins.write_strobe_n <= 1'b1;
		end
	end

	// Data is driven with the strobe and held one cycle past its rise
	// so hold time after write end is met
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dq_out  <= asrc_pkg::DATA_IDLE;
			dq_oe_n <= 1'b1;
		end else if (accept && req_write) begin
			dq_out  <= req_wdata;
			dq_oe_n <= 1'b0;
		end else if (state == asrc_pkg::ST_WR_HOLD) begin
			dq_oe_n <= 1'b1;
		end
	end

	// Read capture; the access time has run out by rd_end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_valid <= 1'b0;
			rd_data  <= asrc_pkg::DATA_IDLE;
		end else begin
			rd_valid <= rd_end;
			if (rd_end) begin
				rd_data <= dq_in;
			end
		end
	end

	// Ready drops on accept and returns when the cycle is done
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			req_ready <= 1'b0;
		end else if (accept) begin
			req_ready <= 1'b0;
		end else begin
			req_ready <= (next_state == asrc_pkg::ST_IDLE);
		end
	end

	// ==========================================================
	// Assertions
	sequence wr_open_s;
		$fell(pins.write_strobe_n) && !pins.chip_sel_n;
	endsequence

	sequence wr_close_s;
		$rose(pins.write_strobe_n) && $rose(pins.chip_sel_n);
	endsequence

	no_contention_a: assert property (
		@(posedge clk) disable iff (rst)
		!dq_oe_n |-> pins.out_gate_n)
		else $error("host drives data while output gate is low");

	addr_with_sel_a: assert property (
		@(posedge clk) disable iff (rst)
		$fell(pins.chip_sel_n) |-> (pins.addr == $past(req_addr))
		##1 $stable(pins.addr))
		else $error("address not set with select or moved at its rise");

	write_hold_a: assert property (
		@(posedge clk) disable iff (rst)
		wr_open_s |-> ##1 wr_close_s ##0 (!dq_oe_n && $stable(dq_out))
		##1 dq_oe_n)
		else $error("write end without data hold or late release");

	write_gate_a: assert property (
		@(posedge clk) disable iff (rst)
		wr_open_s |-> (pins.out_gate_n && !dq_oe_n)
		throughout (##1 $rose(pins.write_strobe_n)))
		else $error("write strobe low with gate open or data off");

	read_answer_a: assert property (
		@(posedge clk) disable iff (rst)
		$fell(pins.out_gate_n) |-> ##1 (rd_valid && pins.out_gate_n
		&& pins.chip_sel_n))
		else $error("read answer not one cycle after access");

	read_data_a: assert property (
		@(posedge clk) disable iff (rst)
		rd_valid |-> rd_data === $past(dq_in))
		else $error("read data not the sampled bus");

	busy_ready_a: assert property (
		@(posedge clk) disable iff (rst)
		!pins.chip_sel_n |-> !req_ready)
		else $error("ready raised while a cycle is open");

endmodule

/* rtl/asrc_pkg.sv */
/*
 * Shared constants and types of the asynchronous static memory host
 * controller: pin widths, timing figures, derived cycle counts, the pin
 * bundle and the sequencer states.
 * Assumes a single 20 MHz clock and the slowest speed grade's figures.
 */
package asrc_pkg;

	// ==========================================================
	// Array geometry
	localparam int ADDR_W = 17;      // 131,072 locations
	localparam int DATA_W = 8;       // One byte per location
	localparam int TMR_W  = 4;

	// ==========================================================
	// Timing figures in ns, slowest grade, and the clock rate
	localparam int CLK_MHZ       = 20;
	localparam int ADDR_ACC_NS   = 15; // address_access_time
	localparam int RD_CYCLE_NS   = 15;
	localparam int WE_PULSE_NS   = 10;
	localparam int WE_OFF_NS     = 7;  // write_strobe_turnoff_delay
	localparam int DATA_SETUP_NS = 8;  // data_setup_to_write_end
	localparam int NS_PER_US     = 1000;

	// Least times round up to whole cycles
	localparam int ACC_RAW = ADDR_ACC_NS > RD_CYCLE_NS ?
		ADDR_ACC_NS : RD_CYCLE_NS;
	localparam int WR_RAW  = WE_PULSE_NS > (WE_OFF_NS + DATA_SETUP_NS) ?
		WE_PULSE_NS : (WE_OFF_NS + DATA_SETUP_NS);
	localparam logic [TMR_W-1:0] ACC_CYC = TMR_W'(
		(ACC_RAW * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
	localparam logic [TMR_W-1:0] WR_CYC  = TMR_W'(
		(WR_RAW * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
	localparam logic [TMR_W-1:0] TMR_ONE  = 4'h1;
	localparam logic [TMR_W-1:0] TMR_ZERO = 4'h0;

	// ==========================================================
	// Idle pin levels
	localparam logic [ADDR_W-1:0] ADDR_IDLE = 17'h0_0000;
	localparam logic [DATA_W-1:0] DATA_IDLE = 8'h00;

	// ==========================================================
	// Address and control pins towards the memory, the control pins all active low
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              chip_sel_n;
		logic              out_gate_n;
		logic              write_strobe_n;
	} asrc_pins_s;

	localparam asrc_pins_s PINS_IDLE = '{
		addr: ADDR_IDLE, chip_sel_n: 1'b1,
		out_gate_n: 1'b1, write_strobe_n: 1'b1};

	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RD_ACC,
		ST_WR_PULSE,
		ST_WR_HOLD
	} asrc_state_e;

endpackage

/* rtl/asrc_timer.sv */
/*
 * Down counter that times the read access and write strobe phases of a memory cycle.
 * Assumes the caller loads it on the cycle a phase begins and waits for
 * the expired flag; a load always wins over the count.
 */
`timescale 1ns/1ps
module asrc_timer (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst,
	// Control
	input  wire logic                       load,
	input  wire logic [asrc_pkg::TMR_W-1:0] load_val,
	// Status
	output wire logic                       expired
);

	logic [asrc_pkg::TMR_W-1:0] count;

	// ==========================================================
	// Count
	// Count down to zero and rest there
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count <= asrc_pkg::TMR_ZERO;
		end else if (load) begin
			count <= load_val;
		end else if (count != asrc_pkg::TMR_ZERO) begin
			count <= count - asrc_pkg::TMR_ONE;
		end
	end

	// Flag is masked in the load cycle so a phase never ends early
	assign expired = (count == asrc_pkg::TMR_ZERO) && !load;

endmodule

/* sim/asrc_ctrl_tb_top.sv */
/*
 * Self-checking bench of the static memory host controller.
 * Assumes the memory model in sim/ and a 20 MHz clock.
 */
`timescale 1ns/1ps
module asrc_ctrl_tb_top;
	logic                 clk       = 1'b0;
	logic                 rst       = 1'b1;
	logic                 req_valid = 1'b0;
	logic                 req_write = 1'b0;
	logic [16:0]          req_addr  = 17'h0_0000;
	logic [7:0]           req_wdata = 8'h00;
	logic                 req_ready;
	logic                 rd_valid;
	logic [7:0]           rd_data;
	asrc_pkg::asrc_pins_s pins;
	logic [7:0]           dq_out;
	logic [7:0]           dq_mem;
	logic                 dq_oe_n;
	logic                 mem_drv;
	wire logic [7:0]      dq_in;
	wire logic [2:0]      ctl;
	int                   err_total = 0;
	int                   n_checks  = 0;
	logic [7:0]           ref_mem [int];

	// ==========================================================
	// Clock, bus resolution and instances
	always #25 clk = ~clk;
	assign dq_in = !dq_oe_n ? dq_out : dq_mem;
	assign ctl = {pins.chip_sel_n, pins.out_gate_n, pins.write_strobe_n};
	asrc_ctrl asrc_ctrl_i (.clk(clk), .rst(rst), .req_valid(req_valid),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
		.pins(pins), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n));
	asrc_mem_model asrc_mem_model_i (.pins(pins), .dq_host(dq_out),
		.dq_mem(dq_mem), .mem_drv(mem_drv));

	// ==========================================================
	// Comparison and closing
	task automatic chk_val(string what, logic [19:0] exp, logic [19:0] got);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// One request; walks the pins cycle by cycle against the reference
	task automatic do_req(logic wr, logic [16:0] a, logic [7:0] d);
		int n;
		n = 0;
		req_valid = 1'b1;
		req_write = wr;
		req_addr  = a;
		req_wdata = d;
		while (req_ready !== 1'b1) begin
			@(negedge clk);
			n++;
			if (n > 20) begin
				err_total++;
				stop_test();
			end
		end
		@(negedge clk);
		req_valid = 1'b0;
		chk_val("addr", 20'(a), 20'(pins.addr));
		chk_val("ctl", wr ? 20'h2 : 20'h1, 20'(ctl));
		if (wr) begin
			chk_val("dq_out", 20'(d), 20'(dq_out));
			chk_val("dq_oe_n", 20'h0, 20'(dq_oe_n));
			ref_mem[int'(a)] = d;
		end
		@(negedge clk);
		chk_val("ctl end", 20'h7, 20'(ctl));
		chk_val("rd_valid", 20'(!wr), 20'(rd_valid));
		chk_val("ready back", 20'(!wr), 20'(req_ready));
		if (wr)
			chk_val("data hold", 20'h0, 20'(dq_oe_n));
		else if (ref_mem.exists(int'(a)))
			chk_val("rd_data", 20'(ref_mem[int'(a)]), 20'(rd_data));
	endtask

	// Host never drives against the memory; idle keeps it deselected
	always @(negedge clk) begin
		if (!rst) begin
			chk_val("contention", 20'h0, 20'(mem_drv && !dq_oe_n));
			if (req_ready === 1'b1)
				chk_val("idle sel", 20'h1, 20'(pins.chip_sel_n));
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		logic [16:0] a;
		void'($urandom(22));
		repeat (12) @(negedge clk);
		chk_val("reset pins", asrc_pkg::PINS_IDLE, pins);
		chk_val("reset oe", 20'h1, 20'(dq_oe_n));
		rst = 1'b0;
		do_req(1'b0, 17'h0_0005, 8'h00);
		do_req(1'b1, 17'h0_0000, 8'hA5);
		do_req(1'b1, 17'h1_FFFF, 8'h5A);
		do_req(1'b0, 17'h0_0000, 8'h00);
		do_req(1'b0, 17'h1_FFFF, 8'h00);
		repeat (60) begin
			a = 17'($urandom) & 17'h1_0007;
			do_req(1'($urandom), a, 8'($urandom));
		end
		// Second reset in mid-run; the memory keeps its contents
		rst = 1'b1;
		repeat (3) @(negedge clk);
		chk_val("mid reset pins", asrc_pkg::PINS_IDLE, pins);
		chk_val("mid reset ready", 20'h0, 20'(req_ready));
		rst = 1'b0;
		do_req(1'b0, 17'h1_FFFF, 8'h00);
		do_req(1'b0, 17'h0_0000, 8'h00);
		stop_test();
	end
endmodule

/* sim/asrc_mem_model.sv */
/*
 * Behavioural 128K x 8 static memory that stands on the controller's pins.
 * Assumes pins come straight from the controller and the bench resolves
 * the shared data bus from dq_host, dq_mem and the host's dq_oe_n.
 */
`timescale 1ns/1ps
module asrc_mem_model (
	// Memory pins
	input  wire asrc_pkg::asrc_pins_s        pins,
	input  wire logic [asrc_pkg::DATA_W-1:0] dq_host,
	// Memory drive
	output      logic [asrc_pkg::DATA_W-1:0] dq_mem,
	output      logic                        mem_drv
);
	// ==========================================================
	// Array: bytes never written stay unknown
	logic [asrc_pkg::DATA_W-1:0] mem [0:(1<<asrc_pkg::ADDR_W)-1];
	logic [asrc_pkg::DATA_W-1:0] wr_d;
	logic [asrc_pkg::ADDR_W-1:0] wr_a;
	logic [asrc_pkg::DATA_W-1:0] last_d = 8'h00;
	wire                         wr_win;

	// Write window is select and strobe low together
	assign wr_win = !pins.chip_sel_n && !pins.write_strobe_n;
	// Drive only when selected, gated and not writing
	assign mem_drv = !pins.chip_sel_n && !pins.out_gate_n
		&& pins.write_strobe_n;
	// Released bus shows the inverse of the last byte, so no stale match
	assign dq_mem = mem_drv ? mem[pins.addr] : ~last_d;

	// Follow byte and place while the window is open
	always @* begin
		if (wr_win) begin
			wr_d = dq_host;
			wr_a = pins.addr;
		end
	end
	// Whichever pin rises first ends the write and stores the byte
	always @(negedge wr_win) begin
		mem[wr_a] = wr_d;
	end
	always @(negedge mem_drv) begin
		last_d = mem[pins.addr];
	end
endmodule
